// [design/bitproc_pkg.sv]
// Shared constants, opcodes and decode helpers for the Boolean/external unit
// Contract
// - External data memory is reached only through indirect addressing forms.
// - External address is 8-bit from pointer reg zero/one, or 16-bit pointer.
// - The accumulator is the only data source or sink for external moves.
// - Constant read via data pointer fetches code byte at accumulator plus pointer.
// - Constant read via PC fetches code byte at accumulator plus next-PC.
// - Constant reads only read program memory and never write it.
// - Bit addresses 00h-7Fh select bits in the internal RAM bit page.
// - Bit addresses 80h-FFh select bits of bit-addressable special registers.
// - RAM bit page holds 128 bits; special space up to 128 bits.
// - Single-bit instructions name their operand by direct bit address only.
// - Each port line is bit-addressable; a bit write leaves other lines alone.
// - Carry is the Boolean accumulator, with own clear, set, complement forms.
// - Carry is also reachable through its own direct bit address.
// - Move, set, clear, complement, AND and OR-with-bit forms, result in carry.
// - No exclusive-OR on single bits; only AND and OR forms exist.
// - Jumps on carry set, carry clear, bit set and bit clear exist.
// - Test-and-clear jump branches only on a one bit and then clears it.
// - Every flags word bit is bit-addressable and testable by bit jumps.
// - Nibble exchange swaps only low nibbles of accumulator and indirect byte.
// - Jump target is next-PC plus signed offset byte, -128 to +127.
package bitproc_pkg;

  // Opcodes
  localparam logic [7:0] OP_XRD_DATA_POINTER   = 8'hE0;
  localparam logic [7:0] OP_XRD_PTR    = 8'hE2;
  localparam logic [7:0] OP_XWR_DATA_POINTER   = 8'hF0;
  localparam logic [7:0] OP_XWR_PTR    = 8'hF2;
  localparam logic [7:0] OP_CONST_DATA_POINTER = 8'h93;
  localparam logic [7:0] OP_CONST_PC   = 8'h83;
  localparam logic [7:0] OP_NIB_XCHG   = 8'hD6;
  localparam logic [7:0] OP_MOV_A_IMM  = 8'h74;
  localparam logic [7:0] OP_MOV_P_IMM  = 8'h78;
  localparam logic [7:0] OP_MOV_DP_IMM = 8'h90;
  localparam logic [7:0] OP_AND_BIT    = 8'h82;
  localparam logic [7:0] OP_AND_NBIT   = 8'hB0;
  localparam logic [7:0] OP_OR_BIT     = 8'h72;
  localparam logic [7:0] OP_OR_NBIT    = 8'hA0;
  localparam logic [7:0] OP_MOV_CB     = 8'hA2;
  localparam logic [7:0] OP_MOV_BC     = 8'h92;
  localparam logic [7:0] OP_CLR_C      = 8'hC3;
  localparam logic [7:0] OP_CLR_B      = 8'hC2;
  localparam logic [7:0] OP_SET_C      = 8'hD3;
  localparam logic [7:0] OP_SET_B      = 8'hD2;
  localparam logic [7:0] OP_CPL_C      = 8'hB3;
  localparam logic [7:0] OP_CPL_B      = 8'hB2;
  localparam logic [7:0] OP_JMP_C1     = 8'h40;
  localparam logic [7:0] OP_JMP_C0     = 8'h50;
  localparam logic [7:0] OP_JMP_B1     = 8'h20;
  localparam logic [7:0] OP_JMP_B0     = 8'h30;
  localparam logic [7:0] OP_JMP_TCLR   = 8'h10;

  // Special register byte addresses
  localparam logic [7:0] SFR_PORT0 = 8'h80;
  localparam logic [7:0] SFR_PORT1 = 8'h90;
  localparam logic [7:0] SFR_PORT2 = 8'hA0;
  localparam logic [7:0] SFR_PORT3 = 8'hB0;
  localparam logic [7:0] SFR_FLAGS = 8'hD0;
  localparam logic [7:0] SFR_ACC   = 8'hE0;
  localparam logic [7:0] SFR_BREG  = 8'hF0;

  localparam logic [6:0] BIT_PAGE_BASE = 7'h20;

  // Flags word fields
  localparam int FLAG_CY     = 7;
  localparam int FLAG_BANK_H = 4;
  localparam int FLAG_BANK_L = 3;
  localparam int FLAG_PAR    = 0;

  // Reset values
  localparam logic [7:0] PORT_RST  = 8'hFF;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] BREG_RST  = 8'h00;

  typedef enum logic [4:0] {
    BOP_NONE, BOP_AND, BOP_ANDN, BOP_OR, BOP_ORN, BOP_MOVCB, BOP_MOVBC,
    BOP_CLRC, BOP_CLRB, BOP_SETC, BOP_SET_BIT_OP, BOP_CPLC, BOP_CPLB,
    BOP_JC1, BOP_JC0, BOP_JB1, BOP_JB0, BOP_JTCLR
  } bit_op_e;

  function automatic bit_op_e bit_op_of(input logic [7:0] opc);
    case (opc)
      OP_AND_BIT:  bit_op_of = BOP_AND;
      OP_AND_NBIT: bit_op_of = BOP_ANDN;
      OP_OR_BIT:   bit_op_of = BOP_OR;
      OP_OR_NBIT:  bit_op_of = BOP_ORN;
      OP_MOV_CB:   bit_op_of = BOP_MOVCB;
      OP_MOV_BC:   bit_op_of = BOP_MOVBC;
      OP_CLR_C:    bit_op_of = BOP_CLRC;
      OP_CLR_B:    bit_op_of = BOP_CLRB;
      OP_SET_C:    bit_op_of = BOP_SETC;
      OP_SET_B:    bit_op_of = BOP_SET_BIT_OP;
      OP_CPL_C:    bit_op_of = BOP_CPLC;
      OP_CPL_B:    bit_op_of = BOP_CPLB;
      OP_JMP_C1:   bit_op_of = BOP_JC1;
      OP_JMP_C0:   bit_op_of = BOP_JC0;
      OP_JMP_B1:   bit_op_of = BOP_JB1;
      OP_JMP_B0:   bit_op_of = BOP_JB0;
      OP_JMP_TCLR: bit_op_of = BOP_JTCLR;
      default:     bit_op_of = BOP_NONE;
    endcase
  endfunction

  // Opcodes whose low bit picks pointer reg zero or one
  function automatic logic uses_ptr_reg(input logic [7:0] opc);
    logic [7:0] o;
    o = {opc[7:1], 1'b0};
    uses_ptr_reg = (o == OP_XRD_PTR) || (o == OP_XWR_PTR) ||
                   (o == OP_NIB_XCHG) || (o == OP_MOV_P_IMM);
  endfunction

endpackage

// [design/bool_alu.sv]
// Single-bit Boolean operation unit with carry as accumulator
`timescale 1ns/1ps
module bool_alu (
  input  wire bitproc_pkg::bit_op_e op,
  input  wire logic                 carry,
  input  wire logic                 bit_in,
  output logic                      carry_nxt,
  output logic                      carry_we,
  output logic                      bit_nxt,
  output logic                      bit_we,
  output logic                      jump
);
  always_comb begin
    carry_nxt = carry;
    carry_we  = 1'b0;
    bit_nxt   = bit_in;
    bit_we    = 1'b0;
    jump      = 1'b0;
    // No exclusive-OR form: unlisted codes decode to no operation
    case (op)
      bitproc_pkg::BOP_AND:   begin carry_nxt = carry & bit_in;  carry_we = 1'b1; end
      bitproc_pkg::BOP_ANDN:  begin carry_nxt = carry & ~bit_in; carry_we = 1'b1; end
      bitproc_pkg::BOP_OR:    begin carry_nxt = carry | bit_in;  carry_we = 1'b1; end
      bitproc_pkg::BOP_ORN:   begin carry_nxt = carry | ~bit_in; carry_we = 1'b1; end
      bitproc_pkg::BOP_MOVCB: begin carry_nxt = bit_in; carry_we = 1'b1; end
      bitproc_pkg::BOP_MOVBC: begin bit_nxt = carry; bit_we = 1'b1; end
      bitproc_pkg::BOP_CLRC:  begin carry_nxt = 1'b0; carry_we = 1'b1; end
      bitproc_pkg::BOP_SETC:  begin carry_nxt = 1'b1; carry_we = 1'b1; end
      bitproc_pkg::BOP_CPLC:  begin carry_nxt = ~carry; carry_we = 1'b1; end
      bitproc_pkg::BOP_CLRB:  begin bit_nxt = 1'b0; bit_we = 1'b1; end
      bitproc_pkg::BOP_SET_BIT_OP:  begin bit_nxt = 1'b1; bit_we = 1'b1; end
      bitproc_pkg::BOP_CPLB:  begin bit_nxt = ~bit_in; bit_we = 1'b1; end
      bitproc_pkg::BOP_JC1:   jump = carry;
      bitproc_pkg::BOP_JC0:   jump = ~carry;
      bitproc_pkg::BOP_JB1:   jump = bit_in;
      bitproc_pkg::BOP_JB0:   jump = ~bit_in;
      bitproc_pkg::BOP_JTCLR: begin
        // Clear only on the taken path
        jump    = bit_in;
        bit_nxt = 1'b0;
        bit_we  = bit_in;
      end
      default: jump = 1'b0;
    endcase
  end
endmodule

// [design/bool_xmove_unit.sv]
// Boolean processor, external data moves and constant reads
`timescale 1ns/1ps
module bool_xmove_unit #(
  parameter int RAM_AW = 7
) (
  input  wire logic        SYS_CLK,
  input  wire logic        ARST_N,
  input  wire logic        START,
  input  wire logic [7:0]  OPCODE,
  input  wire logic [7:0]  OPERAND1,
  input  wire logic [7:0]  OPERAND2,
  input  wire logic [15:0] PC_NEXT,
  input  wire logic        XMEM_ACK,
  input  wire logic [7:0]  XMEM_RDATA,
  input  wire logic        CODE_ACK,
  input  wire logic [7:0]  CODE_RDATA,
  output logic             BUSY,
  output logic             DONE,
  output logic             JUMP_TAKEN,
  output logic      [15:0] JUMP_TARGET,
  output logic      [15:0] XMEM_ADDR,
  output logic      [7:0]  XMEM_WDATA,
  output logic             XMEM_RD,
  output logic             XMEM_WR,
  output logic      [15:0] CODE_ADDR,
  output logic             CODE_RD,
  output logic      [7:0]  ACC_OUT,
  output logic             CARRY_OUT,
  output logic      [7:0]  PORT0_OUT,
  output logic      [7:0]  PORT1_OUT,
  output logic      [7:0]  PORT2_OUT,
  output logic      [7:0]  PORT3_OUT
);
  // Bit page and pointer registers need the full lower 128 bytes
  if (RAM_AW != 7) begin : g_chk
    $error("bool_xmove_unit: RAM_AW must be 7");
  end

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RDA   = 5'b00010,
    ST_PTR   = 5'b00100,
    ST_EXEC  = 5'b01000,
    ST_XWAIT = 5'b10000
  } state_e;

  state_e      state_r, state_nxt;
  logic [7:0]  op_r, a1_r, a2_r, acc_r, flags_r, breg_r;
  logic [15:0] pc_r, data_pointer_r;
  logic [7:0]  port_r [4];
  logic [6:0]  ptr_r, addr_a, ram_raddr, ram_waddr;
  logic [7:0]  ram_rdata, ram_wdata, sfr_byte, src_byte, mod_byte, rel;
  logic [7:0]  sfr_addr;
  logic        ram_we, is_sfr, bit_val, is_xfer, x_read, x_write;
  logic        c_nxt, c_we, b_nxt, b_we, jmp, ack;
  bitproc_pkg::bit_op_e bop;

  function automatic logic [7:0] sfr_read(input logic [7:0] a,
      input logic [7:0] acc, input logic [7:0] flg, input logic [7:0] b,
      input logic [7:0] p0, input logic [7:0] p1, input logic [7:0] p2,
      input logic [7:0] p3);
    case (a)
      bitproc_pkg::SFR_PORT0: sfr_read = p0;
      bitproc_pkg::SFR_PORT1: sfr_read = p1;
      bitproc_pkg::SFR_PORT2: sfr_read = p2;
      bitproc_pkg::SFR_PORT3: sfr_read = p3;
      // Parity follows the accumulator; flags bit 0 as stored is never read
      bitproc_pkg::SFR_FLAGS: sfr_read = {flg[7:1], ^acc};
      bitproc_pkg::SFR_ACC:   sfr_read = acc;
      bitproc_pkg::SFR_BREG:  sfr_read = b;
      default:                sfr_read = 8'h00;
    endcase
  endfunction

  assign bop    = bitproc_pkg::bit_op_of(op_r);
  assign is_sfr = a1_r[7];
  // Bit operand is the direct address in the first operand byte
  assign sfr_addr = {a1_r[7:3], 3'b000};
  assign addr_a = bitproc_pkg::uses_ptr_reg(op_r)
    ? {2'b00, flags_r[bitproc_pkg::FLAG_BANK_H:bitproc_pkg::FLAG_BANK_L],
       2'b00, op_r[0]}
    : bitproc_pkg::BIT_PAGE_BASE + {3'b000, a1_r[6:3]};
  assign sfr_byte = sfr_read(sfr_addr, acc_r, flags_r, breg_r,
                             port_r[0], port_r[1], port_r[2], port_r[3]);
  assign src_byte = is_sfr ? sfr_byte : ram_rdata;
  assign bit_val  = src_byte[a1_r[2:0]];
  // Only the addressed bit changes in the written-back byte
  always_comb begin
    mod_byte = src_byte;
    mod_byte[a1_r[2:0]] = b_nxt;
  end
  assign rel = (bop == bitproc_pkg::BOP_JC1 || bop == bitproc_pkg::BOP_JC0)
             ? a1_r : a2_r;
  assign x_read  = {op_r[7:1], 1'b0} == bitproc_pkg::OP_XRD_PTR ||
                   op_r == bitproc_pkg::OP_XRD_DATA_POINTER;
  assign x_write = {op_r[7:1], 1'b0} == bitproc_pkg::OP_XWR_PTR ||
                   op_r == bitproc_pkg::OP_XWR_DATA_POINTER;
  assign is_xfer = x_read || x_write ||
                   op_r == bitproc_pkg::OP_CONST_DATA_POINTER ||
                   op_r == bitproc_pkg::OP_CONST_PC;
  assign ack = (XMEM_ACK && (XMEM_RD || XMEM_WR)) || (CODE_ACK && CODE_RD);

  bool_alu u_alu (
    .op        (bop),
    .carry     (flags_r[bitproc_pkg::FLAG_CY]),
    .bit_in    (bit_val),
    .carry_nxt (c_nxt),
    .carry_we  (c_we),
    .bit_nxt   (b_nxt),
    .bit_we    (b_we),
    .jump      (jmp)
  );

  // RAM port steering; pointer byte bit 7 ignored, no upper 128 bytes
  always_comb begin
    ram_raddr = addr_a;
    if (state_r == ST_PTR) begin
      ram_raddr = ram_rdata[6:0];
    end else if (state_r == ST_EXEC &&
                 op_r[7:1] == bitproc_pkg::OP_NIB_XCHG[7:1]) begin
      ram_raddr = ptr_r;
    end
  end

  always_comb begin
    ram_we    = 1'b0;
    ram_waddr = addr_a;
    ram_wdata = mod_byte;
    if (state_r == ST_EXEC) begin
      if (op_r[7:1] == bitproc_pkg::OP_NIB_XCHG[7:1]) begin
        ram_we    = 1'b1;
        ram_waddr = ptr_r;
        ram_wdata = {ram_rdata[7:4], acc_r[3:0]};
      end else if (op_r[7:1] == bitproc_pkg::OP_MOV_P_IMM[7:1]) begin
        ram_we    = 1'b1;
        ram_wdata = a1_r;
      end else if (b_we && !is_sfr) begin
        ram_we    = 1'b1;
      end
    end
  end

  internal_ram #(.AW(RAM_AW), .DW(8)) u_ram (
    .clk    (SYS_CLK),
    .arst_n (ARST_N),
    .raddr  (ram_raddr),
    .rdata  (ram_rdata),
    .we     (ram_we),
    .waddr  (ram_waddr),
    .wdata  (ram_wdata)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  if (START) state_nxt = ST_RDA;
      ST_RDA:   state_nxt = (op_r[7:1] == bitproc_pkg::OP_NIB_XCHG[7:1])
                            ? ST_PTR : ST_EXEC;
      ST_PTR:   state_nxt = ST_EXEC;
      ST_EXEC:  state_nxt = is_xfer ? ST_XWAIT : ST_IDLE;
      ST_XWAIT: if (ack) state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= ST_IDLE;
      BUSY    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      BUSY    <= state_nxt != ST_IDLE;
    end
  end

  // Instruction capture
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      op_r  <= 8'h00;
      a1_r  <= 8'h00;
      a2_r  <= 8'h00;
      pc_r  <= 16'h0000;
      ptr_r <= 7'h00;
    end else begin
      if (state_r == ST_IDLE && START) begin
        op_r <= OPCODE;
        a1_r <= OPERAND1;
        a2_r <= OPERAND2;
        pc_r <= PC_NEXT;
      end
      if (state_r == ST_PTR) begin
        ptr_r <= ram_rdata[6:0];
      end
    end
  end

  // Accumulator
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      acc_r <= bitproc_pkg::ACC_RST;
    end else if (state_r == ST_EXEC) begin
      if (op_r == bitproc_pkg::OP_MOV_A_IMM) begin
        acc_r <= a1_r;
      end else if (op_r[7:1] == bitproc_pkg::OP_NIB_XCHG[7:1]) begin
        acc_r <= {acc_r[7:4], ram_rdata[3:0]};
      end else if (b_we && is_sfr && sfr_addr == bitproc_pkg::SFR_ACC) begin
        acc_r <= mod_byte;
      end
    end else if (state_r == ST_XWAIT) begin
      if (XMEM_ACK && XMEM_RD) begin
        acc_r <= XMEM_RDATA;
      end else if (CODE_ACK && CODE_RD) begin
        acc_r <= CODE_RDATA;
      end
    end
  end

  // Flags word; carry reachable by its direct bit address too
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      flags_r <= bitproc_pkg::FLAGS_RST;
    end else if (state_r == ST_EXEC) begin
      if (c_we) begin
        flags_r[bitproc_pkg::FLAG_CY] <= c_nxt;
      end else if (b_we && is_sfr && sfr_addr == bitproc_pkg::SFR_FLAGS) begin
        flags_r <= mod_byte;
      end
    end
  end

  // Ports and B register, one bit changed per write
  for (genvar i = 0; i < 4; i++) begin : g_port
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        port_r[i] <= bitproc_pkg::PORT_RST;
      end else if (state_r == ST_EXEC && b_we && is_sfr &&
                   sfr_addr == (bitproc_pkg::SFR_PORT0 + 8'(i * 16))) begin
        port_r[i] <= mod_byte;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      breg_r <= bitproc_pkg::BREG_RST;
    end else if (state_r == ST_EXEC && b_we && is_sfr &&
                 sfr_addr == bitproc_pkg::SFR_BREG) begin
      breg_r <= mod_byte;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      data_pointer_r <= 16'h0000;
    end else if (state_r == ST_EXEC && op_r == bitproc_pkg::OP_MOV_DP_IMM) begin
      data_pointer_r <= {a1_r, a2_r};
    end
  end

  // External data and code requests, held until acknowledged
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      XMEM_ADDR  <= 16'h0000;
      XMEM_WDATA <= 8'h00;
      XMEM_RD    <= 1'b0;
      XMEM_WR    <= 1'b0;
      CODE_ADDR  <= 16'h0000;
      CODE_RD    <= 1'b0;
    end else if (state_r == ST_EXEC) begin
      // Indirect only: address from a pointer, never from the opcode
      XMEM_ADDR  <= op_r[1] ? {8'h00, ram_rdata} : data_pointer_r;
      XMEM_WDATA <= acc_r;
      XMEM_RD    <= x_read;
      XMEM_WR    <= x_write;
      CODE_ADDR  <= (op_r == bitproc_pkg::OP_CONST_PC)
                    ? pc_r + {8'h00, acc_r}
                    : data_pointer_r + {8'h00, acc_r};
      // Code side has no write strobe at all
      CODE_RD    <= op_r == bitproc_pkg::OP_CONST_DATA_POINTER ||
                    op_r == bitproc_pkg::OP_CONST_PC;
    end else if (ack) begin
      XMEM_RD <= 1'b0;
      XMEM_WR <= 1'b0;
      CODE_RD <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      DONE        <= 1'b0;
      JUMP_TAKEN  <= 1'b0;
      JUMP_TARGET <= 16'h0000;
    end else begin
      DONE       <= (state_r == ST_EXEC && !is_xfer) ||
                    (state_r == ST_XWAIT && ack);
      JUMP_TAKEN <= state_r == ST_EXEC && jmp;
      if (state_r == ST_EXEC) begin
        JUMP_TARGET <= pc_r + {{8{rel[7]}}, rel};
      end
    end
  end

  assign ACC_OUT   = acc_r;
  assign CARRY_OUT = flags_r[bitproc_pkg::FLAG_CY];
  assign PORT0_OUT = port_r[0];
  assign PORT1_OUT = port_r[1];
  assign PORT2_OUT = port_r[2];
  assign PORT3_OUT = port_r[3];

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  xread_acc_a: assert property (XMEM_RD && XMEM_ACK |=>
    ACC_OUT == $past(XMEM_RDATA)) else $error("acc not loaded");
  xwrite_data_a: assert property (XMEM_WR |->
    XMEM_WDATA == acc_r) else $error("write data not acc");
  xaddr_ptr_a: assert property ((XMEM_RD || XMEM_WR) && op_r[1] |->
    XMEM_ADDR[15:8] == 8'h00) else $error("8-bit address high");
  xaddr_data_pointer_a: assert property ((XMEM_RD || XMEM_WR) && !op_r[1] |->
    XMEM_ADDR == data_pointer_r) else $error("16-bit address wrong");
  const_data_pointer_a: assert property (CODE_RD &&
    op_r == bitproc_pkg::OP_CONST_DATA_POINTER |-> CODE_ADDR == data_pointer_r + {8'h00, acc_r})
    else $error("constant address wrong");
  const_pc_a: assert property (CODE_RD &&
    op_r == bitproc_pkg::OP_CONST_PC |-> CODE_ADDR == pc_r + {8'h00, acc_r})
    else $error("pc constant address wrong");
  const_nowr_a: assert property (CODE_RD |-> !XMEM_WR)
    else $error("write during constant read");
  tclr_jump_a: assert property (state_r == ST_EXEC &&
    bop == bitproc_pkg::BOP_JTCLR |=> JUMP_TAKEN == $past(bit_val))
    else $error("test-and-clear jump wrong");
  jump_target_a: assert property (JUMP_TAKEN |->
    JUMP_TARGET == pc_r + {{8{rel[7]}}, rel}) else $error("bad target");
  nibble_swap_a: assert property (state_r == ST_EXEC &&
    op_r[7:1] == bitproc_pkg::OP_NIB_XCHG[7:1] |=>
    ACC_OUT == {$past(acc_r[7:4]), $past(ram_rdata[3:0])})
    else $error("nibble exchange wrong");
  port_onebit_a: assert property (!$stable(PORT1_OUT) |->
    $onehot(PORT1_OUT ^ $past(PORT1_OUT))) else $error("port burst write");
  carry_set_a: assert property (state_r == ST_EXEC &&
    op_r == bitproc_pkg::OP_SET_C |=> CARRY_OUT) else $error("carry not set");

  xread_c: cover property (XMEM_RD && XMEM_ACK);
  const_c: cover property (CODE_RD && CODE_ACK);
  tclr_c:  cover property (JUMP_TAKEN && op_r == bitproc_pkg::OP_JMP_TCLR);
  swap_c:  cover property (DONE && op_r == bitproc_pkg::OP_NIB_XCHG);
endmodule

// [design/internal_ram.sv]
// Lower internal RAM with registered read data
`timescale 1ns/1ps
module internal_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata
);
  logic [DW-1:0] mem [2**AW];

  if (AW < 1 || DW < 1) begin : g_chk
    $error("internal_ram: bad geometry");
  end

  // Array left unreset; contents undefined until written
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// [test/mem_model.sv]
// Behavioural external data memory and program memory
`timescale 1ns/1ps
module mem_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  dly,
  input  wire logic [15:0] xmem_addr,
  input  wire logic [7:0]  xmem_wdata,
  input  wire logic        xmem_rd,
  input  wire logic        xmem_wr,
  output logic             xmem_ack,
  output logic      [7:0]  xmem_rdata,
  input  wire logic [15:0] code_addr,
  input  wire logic        code_rd,
  output logic             code_ack,
  output logic      [7:0]  code_rdata,
  output logic      [15:0] wr_addr,
  output logic      [7:0]  wr_data,
  output int               wr_cnt
);
  logic [3:0] cnt;
  logic [7:0] xv;
  logic [7:0] cv;
  assign xv = xmem_addr[7:0] ^ 8'h5A;
  // Both address bytes feed the data, so a lost carry shows
  assign cv = code_addr[7:0] + code_addr[15:8];
  // Off-ack data inverted so a stale sample never matches
  assign xmem_rdata = xmem_ack ? xv : ~xv;
  assign code_rdata = code_ack ? cv : ~cv;
  always @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      xmem_ack <= 1'b0;
      code_ack <= 1'b0;
    end else begin
      xmem_ack <= (xmem_rd | xmem_wr) && cnt >= dly;
      code_ack <= code_rd && cnt >= dly;
      cnt <= (xmem_rd | xmem_wr | code_rd) ? cnt + 4'h1 : 4'h0;
    end
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_cnt <= 0;
    end else if (xmem_wr && xmem_ack) begin
      wr_addr <= xmem_addr;
      wr_data <= xmem_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule

// [test/testbench.sv]
// Self-checking bench for the Boolean and external move unit
`timescale 1ns/1ps
module testbench;
  logic SYS_CLK = 0, ARST_N = 0, START = 0;
  logic [7:0] OPCODE = 8'h00, OPERAND1 = 8'h00, OPERAND2 = 8'h00;
  logic [15:0] PC_NEXT = 16'h10F0;
  logic [3:0] dly = 4'h2;
  logic XMEM_ACK, CODE_ACK, DONE, JUMP_TAKEN, XMEM_RD, XMEM_WR, CODE_RD;
  logic CARRY_OUT, BUSY;
  logic [7:0] XMEM_RDATA, CODE_RDATA, XMEM_WDATA, ACC_OUT, wr_data;
  logic [7:0] PORT0_OUT, PORT1_OUT, PORT2_OUT, PORT3_OUT;
  logic [15:0] JUMP_TARGET, XMEM_ADDR, CODE_ADDR, wr_addr;
  logic tk;
  logic [15:0] tg;
  int wr_cnt, n_mismatch = 0, total_checks = 0;
  bool_xmove_unit uut (.*);
  mem_model mem (.clk(SYS_CLK), .arst_n(ARST_N), .dly(dly),
    .xmem_addr(XMEM_ADDR), .xmem_wdata(XMEM_WDATA), .xmem_rd(XMEM_RD),
    .xmem_wr(XMEM_WR), .xmem_ack(XMEM_ACK), .xmem_rdata(XMEM_RDATA),
    .code_addr(CODE_ADDR), .code_rd(CODE_RD), .code_ack(CODE_ACK),
    .code_rdata(CODE_RDATA), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_cnt(wr_cnt));
  initial begin
    forever #4 SYS_CLK = ~SYS_CLK;
  end
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Issue one instruction, wait a bounded time for its end
  task run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    int n;
    @(negedge SYS_CLK);
    START = 1;
    OPCODE = op;
    OPERAND1 = a;
    OPERAND2 = b;
    @(negedge SYS_CLK);
    START = 0;
    n = 0;
    while (DONE !== 1'b1 && n < 40) begin
      @(negedge SYS_CLK);
      n++;
    end
    chk("done", {15'h0, DONE}, 16'h0001);
    tk = JUMP_TAKEN;
    tg = JUMP_TARGET;
  endtask
  task t_bits;
    // Entry: opcode, bit, rel, then carry and taken flags
    logic [31:0] tb [25] = '{32'h30D01001, 32'hD3000002, 32'hC2930002,
      32'h82940002, 32'h82930000, 32'hA0930002, 32'hB0940000,
      32'h72940002, 32'hB3000000, 32'hA2940002, 32'h92800002,
      32'hC3000000, 32'h92800000, 32'hD2D70002, 32'hB2D70000,
      32'h40800000, 32'h50800001, 32'hD2010000, 32'h20017F01,
      32'h30017F00, 32'h10017F01, 32'h10017F00, 32'h30010501,
      32'h10940201, 32'hD3000002};
    logic [7:0] r;
    foreach (tb[i]) begin
      run(tb[i][31:24], tb[i][23:16], tb[i][15:8]);
      // Carry jumps carry rel in the first operand, bit jumps in the second
      r = (tb[i][31:28] == 4'h4 || tb[i][31:28] == 4'h5) ? tb[i][23:16]
                                                          : tb[i][15:8];
      chk("carry", {15'h0, CARRY_OUT}, {15'h0, tb[i][1]});
      chk("taken", {15'h0, tk}, {15'h0, tb[i][0]});
      if (tk === 1'b1)
        chk("target", tg, PC_NEXT + {{8{r[7]}}, r});
    end
    chk("port0", {8'h0, PORT0_OUT}, 16'h00FE);
    chk("port1", {8'h0, PORT1_OUT}, 16'h00E7);
    $display("bit processor test done");
  endtask
  task t_xmove;
    run(8'h74, 8'h3C, 8'h00);
    run(8'h90, 8'h12, 8'h34);
    run(8'hF0, 8'h00, 8'h00);
    chk("wr addr", wr_addr, 16'h1234);
    chk("wr data", {8'h0, wr_data}, 16'h003C);
    run(8'hE0, 8'h00, 8'h00);
    chk("acc", {8'h0, ACC_OUT}, 16'h006E);
    run(8'h78, 8'h45, 8'h00);
    run(8'hE2, 8'h00, 8'h00);
    run(8'hF2, 8'h00, 8'h00);
    chk("wr addr", wr_addr, 16'h0045);
    chk("wr data", {8'h0, wr_data}, 16'h001F);
    run(8'h79, 8'h67, 8'h00);
    run(8'hF3, 8'h00, 8'h00);
    chk("wr addr", wr_addr, 16'h0067);
    run(8'hE3, 8'h00, 8'h00);
    chk("acc", {8'h0, ACC_OUT}, 16'h003D);
    $display("external move test done");
  endtask
  task t_const;
    int wc;
    wc = wr_cnt;
    dly = 4'h0;
    run(8'h74, 8'hF0, 8'h00);
    run(8'h93, 8'h00, 8'h00);
    chk("acc", {8'h0, ACC_OUT}, 16'h0037);
    run(8'h83, 8'h00, 8'h00);
    chk("acc", {8'h0, ACC_OUT}, 16'h0038);
    chk("writes", wc[15:0], wr_cnt[15:0]);
    run(8'h74, 8'hA5, 8'h00);
    // Pointer one aims at byte 00h, which holds a known 20h
    run(8'h78, 8'h20, 8'h00);
    run(8'h79, 8'h00, 8'h00);
    run(8'hD7, 8'h00, 8'h00);
    chk("acc high", {12'h0, ACC_OUT[7:4]}, 16'h000A);
    chk("acc", {8'h0, ACC_OUT}, 16'h00A0);
    run(8'hD7, 8'h00, 8'h00);
    chk("acc", {8'h0, ACC_OUT}, 16'h00A5);
    $display("constant and nibble test done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #40000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (16) @(negedge SYS_CLK);
    ARST_N = 1;
    chk("port1 rst", {8'h0, PORT1_OUT}, 16'h00FF);
    chk("acc rst", {8'h0, ACC_OUT}, 16'h0000);
    t_bits;
    t_xmove;
    t_const;
    print_verdict;
  end
endmodule
